/* File: tb/porc_button.sv */
/*
 * Push-button model on the reset pad.
 * Assumes the bench pulses go_in for one cycle with the hold length.
 */
`timescale 1ns/10ps
module porc_button (
  // Clock
  input  wire logic        sys_clk_in,
  // Command
  input  wire logic        go_in,
  input  wire logic [15:0] len_in,
  // Pad
  output logic             pad_out
);
  logic [15:0] cnt_ff = 16'h0000;

  // Released pad falls to its pull-down level
  assign pad_out = (cnt_ff != 16'h0000);

  always_ff @(posedge sys_clk_in) begin
    if (go_in) begin
      cnt_ff <= len_in;
    end else if (cnt_ff != 16'h0000) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end
endmodule

/* File: tb/porc_top_tb.sv */
/*
 * Self-checking bench for the reset controller.
 * Assumes the button model on the pad and a bench-made slow oscillator.
 */
`timescale 1ns/10ps
module porc_top_tb;
  localparam int PULSE = porc_pkg::RST_PULSE_CYC;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        slow_clk   = 1'b0;
  logic [11:0] gpio       = 12'h000;
  logic [2:0]  sup        = 3'h7;
  logic        wake       = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h00000000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        go         = 1'b0;
  logic [15:0] len        = 16'h0000;
  logic [31:0] seed       = 32'h2763256c;
  logic        pad;
  logic [31:0] rdata;
  logic        por, hw, sw, boot, rc_en, povr;
  int          bad_count  = 0;
  int          check_count = 0;
  int          cyc        = 0;
  int          wn;
  int          m_stat;

  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // Slow oscillator: 16 system cycles per period, unrelated phase
  initial begin
    forever #403 slow_clk = ~slow_clk;
  end

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  porc_button btn (.sys_clk_in(sys_clk_in), .go_in(go), .len_in(len), .pad_out(pad));

  porc_top #(.TICKS(4)) dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .rst_pad_in(pad), .gpio_in(gpio),
    .slow_rc_clk_in(slow_clk), .vdd_ok_in(sup[0]), .vbat_high_ok_in(sup[1]), .vbat_low_ok_in(sup[2]),
    .wake_event_in(wake), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .por_rst_out(por), .hw_rst_out(hw), .sw_rst_out(sw),
    .boot_req_out(boot), .slow_rc_en_out(rc_en), .pull_override_out(povr)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic line(input int k);
    return (k == 0) ? por : ((k == 1) ? hw : sw);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // Wait for a reset line, measure its width, then check the boot pulse
  task automatic pulse(input int k, input int lim, input int w);
    int n;
    #1;
    wn = 0;
    while (line(k) !== 1'b1 && wn < lim) begin
      @(posedge sys_clk_in);
      #1;
      wn++;
    end
    chk(line(k), 1'b1);
    n = 0;
    while (line(k) === 1'b1 && n < 400) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (w > 0) begin
      chk(n, w);
      chk(boot, k != 2);
    end
    m_stat = 1 << k;
  endtask

  task automatic quiet(input int k, input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
      if (line(k) !== 1'b0) h++;
    end
    chk(h, 0);
  endtask

  task automatic press(input int c);
    @(posedge sys_clk_in);
    go <= 1'b1;
    len <= c[15:0];
    @(posedge sys_clk_in);
    go <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    int h;
    logic [31:0] r;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    pulse(0, 40, 0);
    rd_chk(porc_pkg::OFS_RST_STAT, m_stat);
    rd_chk(porc_pkg::OFS_POR_TIMER, 32'h18);
    rd_chk(porc_pkg::OFS_SYS_CTRL, 32'h2);
    rd_chk(8'h20, 32'h0);
    wr_reg(porc_pkg::OFS_SCRATCH, 32'h5a5a);
    wr_reg(porc_pkg::OFS_PIN_SEL, 32'h13);
    wr_reg(porc_pkg::OFS_POR_TIMER, 32'h2);
    r = xs();
    wr_reg(porc_pkg::OFS_CPU_RST, r | 32'h1);
    quiet(2, 10);
    wr_reg(porc_pkg::OFS_CPU_RST, porc_pkg::CPU_RST_KEY);
    pulse(2, 5, PULSE);
    rd_chk(porc_pkg::OFS_RST_STAT, m_stat);
    rd_chk(porc_pkg::OFS_SCRATCH, 32'h0);
    rd_chk(porc_pkg::OFS_PIN_SEL, 32'h10);
    rd_chk(porc_pkg::OFS_POR_TIMER, 32'h2);
    wr_reg(porc_pkg::OFS_SYS_CTRL, 32'h3);
    pulse(2, 5, PULSE);
    // Random pin traffic must not matter while no pin is selected
    h = 0;
    repeat (300) begin
      r = xs();
      @(posedge sys_clk_in);
      gpio <= r[11:0];
      if (por !== 1'b0) h++;
    end
    chk(h, 0);
    @(posedge sys_clk_in);
    gpio <= 12'h000;
    // Two short presses: the count must not carry over
    repeat (2) begin
      wr_reg(porc_pkg::OFS_SYS_CTRL, 32'h0);
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk(rc_en, 1'b0);
      press(100);
      repeat (4) @(posedge sys_clk_in);
      #1;
      chk(rc_en, 1'b1);
      pulse(1, 200, PULSE);
    end
    rd_chk(porc_pkg::OFS_RST_STAT, m_stat);
    rd_chk(porc_pkg::OFS_POR_TIMER, 32'h2);
    press(400);
    pulse(0, 250, PULSE);
    chk(wn > 100 && wn < 150, 1'b1);
    quiet(1, 300);
    rd_chk(porc_pkg::OFS_RST_STAT, m_stat);
    rd_chk(porc_pkg::OFS_POR_TIMER, 32'h18);
    wr_reg(porc_pkg::OFS_PIN_SEL, 32'h13);
    wr_reg(porc_pkg::OFS_POR_TIMER, 32'h1);
    gpio <= 12'h008;
    pulse(0, 150, PULSE);
    quiet(0, 150);
    gpio <= 12'h020;
    wr_reg(porc_pkg::OFS_PIN_SEL, 32'h05);
    wr_reg(porc_pkg::OFS_POR_TIMER, 32'h1);
    quiet(0, 150);
    gpio <= 12'h000;
    pulse(0, 150, PULSE);
    // Pin then pad overlap; pad alone would take far longer
    wr_reg(porc_pkg::OFS_PIN_SEL, 32'h13);
    wr_reg(porc_pkg::OFS_POR_TIMER, 32'h2);
    gpio <= 12'h008;
    repeat (60) @(posedge sys_clk_in);
    press(200);
    repeat (38) @(posedge sys_clk_in);
    gpio <= 12'h000;
    pulse(0, 60, PULSE);
    repeat (150) @(posedge sys_clk_in);
    wr_reg(porc_pkg::OFS_PULL_OVR, 32'h1);
    wr_reg(porc_pkg::OFS_PMU_CTRL, 32'h1);
    #1;
    chk(povr, 1'b1);
    repeat (2) begin
      @(posedge sys_clk_in);
      wake <= 1'b1;
      @(posedge sys_clk_in);
      wake <= 1'b0;
      if (m_stat != 2) begin
        pulse(1, 5, PULSE);
        rd_chk(porc_pkg::OFS_RST_STAT, m_stat | 8);
        rd_chk(porc_pkg::OFS_PMU_CTRL, 32'h0);
        chk(povr, 1'b0);
      end else begin
        quiet(1, 30);
      end
    end
    // Each supply monitor on its own must hold power-on
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk_in);
      sup <= 3'h7 ^ (3'h1 << k);
      repeat (10) @(posedge sys_clk_in);
      sup <= 3'h7;
      pulse(0, 10, 0);
      rd_chk(porc_pkg::OFS_RST_STAT, m_stat);
    end
    summarize();
  end
endmodule

/* File: verilog/porc_delay_timer.sv */
/*
 * Power-on delay counter: counts slow-oscillator ticks while run is high.
 * Assumes tick is a one-cycle pulse on the system clock.
 */
`timescale 1ns/10ps
module porc_delay_timer #(
  parameter int unsigned FW    = 7,
  parameter int unsigned TICKS = porc_pkg::TICKS_PER_UNIT
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  // Control
  input  wire logic          run_in,
  input  wire logic          tick_in,
  input  wire logic [FW-1:0] factor_in,
  // Result
  output logic               expire_out
);
  localparam int unsigned CW = FW + $clog2(TICKS);
  logic [CW-1:0] cnt_ff;
  logic [CW:0]   limit;
  logic          last;

  assign limit = (CW+1)'(factor_in) * (CW+1)'(TICKS);
  assign last  = ((CW+1)'(cnt_ff) + (CW+1)'(1)) >= limit;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff     <= '0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= run_in && tick_in && last;
      if (!run_in || (tick_in && last)) begin
        cnt_ff <= '0;
      end else if (tick_in) begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  property p_clear_on_release;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !run_in |=> (cnt_ff == '0) && !expire_out;
  endproperty
  a_clear_on_release: assert property (p_clear_on_release)
    else $error("delay counter not cleared on release");
endmodule

/* File: verilog/porc_pkg.sv */
/*
 * Constants, register map and types for the power-on reset controller.
 * Assumes a 20 MHz system clock and a slow RC oscillator near 32 kHz.
 */
package porc_pkg;
  // System clock and reset pulse timing
  localparam int unsigned SYS_CLK_HZ    = 20_000_000;
  localparam int unsigned RST_PULSE_NS  = 1000;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  // Slow oscillator periods per unit of the delay factor
  localparam int unsigned TICKS_PER_UNIT = 4096;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_SYS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CPU_RST   = 8'h04;
  localparam logic [7:0] OFS_PMU_CTRL  = 8'h08;
  localparam logic [7:0] OFS_PIN_SEL   = 8'h0c;
  localparam logic [7:0] OFS_POR_TIMER = 8'h10;
  localparam logic [7:0] OFS_RST_STAT  = 8'h14;
  localparam logic [7:0] OFS_PULL_OVR  = 8'h18;
  localparam logic [7:0] OFS_SCRATCH   = 8'h1c;
  // Key for the processor system-reset request
  localparam logic [31:0] CPU_RST_KEY = 32'h05fa0004;
  // Field positions
  localparam int unsigned SYSC_SOFT_BIT = 0;
  localparam int unsigned SYSC_RC_EN_BIT = 1;
  localparam int unsigned PMU_ROW_BIT   = 0;
  localparam int unsigned PIN_POL_BIT   = 4;
  localparam int unsigned STAT_POR_BIT  = 0;
  localparam int unsigned STAT_HW_BIT   = 1;
  localparam int unsigned STAT_SW_BIT   = 2;
  localparam int unsigned STAT_WAKE_BIT = 3;
  // Values after reset
  localparam logic [6:0] POR_TIME_RST = 7'h18;
  localparam logic [3:0] PIN_SEL_RST  = 4'h0;
  localparam logic       PIN_POL_RST  = 1'b0;
  localparam logic       RC_EN_RST    = 1'b1;
  localparam logic [3:0] STAT_RST     = 4'h1;
  // Reset kind being issued
  typedef enum logic [1:0] {
    PORC_IDLE = 2'b00,
    PORC_POR  = 2'b01,
    PORC_HW   = 2'b10,
    PORC_SW   = 2'b11
  } porc_kind_t;
endpackage

/* File: verilog/porc_sync.sv */
/*
 * Two-stage synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level; no bus coherence is promised.
 */
`timescale 1ns/10ps
module porc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // First stage read only by the second
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* File: verilog/porc_top.sv */
/*
 * Power-on reset controller: merges supply monitors, reset pad, a chosen
 * GPIO and software requests into power-on, hardware and software resets.
 * Assumes a 20 MHz system clock, asynchronous pins and a plain register port.
 */
`timescale 1ns/10ps
module porc_top #(
  parameter int unsigned GPIO_N = 12,
  parameter int unsigned SEL_W  = 4,
  parameter int unsigned TICKS  = porc_pkg::TICKS_PER_UNIT
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // Pins and monitors (asynchronous)
  input  wire logic              rst_pad_in,
  input  wire logic [GPIO_N-1:0] gpio_in,
  input  wire logic              slow_rc_clk_in,
  input  wire logic              vdd_ok_in,
  input  wire logic              vbat_high_ok_in,
  input  wire logic              vbat_low_ok_in,
  // Sleep controller (same clock)
  input  wire logic              wake_event_in,
  // Register port
  input  wire logic [7:0]        addr_in,
  input  wire logic [31:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [31:0]       rdata_out,
  // Reset lines and boot
  output logic                   por_rst_out,
  output logic                   hw_rst_out,
  output logic                   sw_rst_out,
  output logic                   boot_req_out,
  // Oscillator and pull control
  output logic                   slow_rc_en_out,
  output logic                   pull_override_out
);
  localparam int unsigned SW_N = GPIO_N + 5;
  localparam logic [7:0] PULSE_LOAD = 8'(porc_pkg::RST_PULSE_CYC - 1);

  logic [SW_N-1:0]      sync_q;
  logic [GPIO_N-1:0]    gpio_s;
  logic                 pad_s, rc_s, sup_ok, tick, gpio_act, src_run, timer_fire, short_press;
  logic                 rc_q_ff, pad_q_ff, pad_spent_ff, rc_en_ff, row_ff, pin_pol_ff;
  logic                 req_por, req_hw, req_sw, wake_hit, key_hit, soft_hit, dom_por, dom_hw, dom_sw;
  porc_pkg::porc_kind_t kind_ff, nxt_kind;
  logic [7:0]           cnt_ff, nxt_cnt;
  logic [SEL_W-1:0]     pin_sel_ff;
  logic [6:0]           por_time_ff;
  logic [3:0]           stat_ff;
  logic [31:0]          scratch_ff;

  // Pins cross into the system clock first
  porc_sync #(.W (SW_N)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({vbat_low_ok_in, vbat_high_ok_in, vdd_ok_in,
                  slow_rc_clk_in, gpio_in, rst_pad_in}),
    .sync_out   (sync_q)
  );

  assign pad_s  = sync_q[0];
  assign gpio_s = sync_q[GPIO_N:1];
  assign rc_s   = sync_q[GPIO_N+1];
  assign sup_ok = &sync_q[SW_N-1:GPIO_N+2];

  // Slow oscillator edge gives the count tick
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rc_q_ff <= 1'b0;
    end else begin
      rc_q_ff <= rc_s;
    end
  end
  assign tick = rc_s && !rc_q_ff;

  // Selected pin is only watched, never driven; out-of-range reads inactive
  function automatic logic gpio_pick(input logic [SEL_W-1:0] sel, input logic [GPIO_N-1:0] vec, input logic pol);
    logic hit;
    hit = 1'b0;
    if (sel != '0 && int'(sel) < GPIO_N) begin
      hit = (vec[sel] == pol);
    end
    return hit;
  endfunction
  assign gpio_act = gpio_pick(pin_sel_ff, gpio_s, pin_pol_ff);

  // Pad may expire the timer only once per press
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_q_ff     <= 1'b0;
      pad_spent_ff <= 1'b0;
    end else begin
      pad_q_ff <= pad_s;
      if (!pad_s) begin
        pad_spent_ff <= 1'b0;
      end else if (timer_fire) begin
        pad_spent_ff <= 1'b1;
      end
    end
  end

  // Any active source keeps the run going, so overlaps add up
  assign src_run = (gpio_act || (pad_s && !pad_spent_ff)) && !dom_por;

  porc_delay_timer #(.FW (7), .TICKS (TICKS)) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (src_run),
    .tick_in    (tick),
    .factor_in  (por_time_ff),
    .expire_out (timer_fire)
  );

  // Release before expiry means a short press
  assign short_press = pad_q_ff && !pad_s && !pad_spent_ff;
  assign wake_hit    = wake_event_in && row_ff;
  assign key_hit     = wr_in && addr_in == porc_pkg::OFS_CPU_RST && wdata_in == porc_pkg::CPU_RST_KEY;
  assign soft_hit    = wr_in && addr_in == porc_pkg::OFS_SYS_CTRL && wdata_in[porc_pkg::SYSC_SOFT_BIT];

  assign req_por = timer_fire || !sup_ok;
  assign req_hw  = short_press || wake_hit;
  assign req_sw  = key_hit || soft_hit;

  // Power-on beats hardware, hardware beats software
  always_comb begin
    nxt_kind = kind_ff;
    nxt_cnt  = cnt_ff;
    if (req_por) begin
      nxt_kind = porc_pkg::PORC_POR;
      nxt_cnt  = PULSE_LOAD;
    end else if (req_hw && kind_ff != porc_pkg::PORC_POR) begin
      nxt_kind = porc_pkg::PORC_HW;
      nxt_cnt  = PULSE_LOAD;
    end else if (req_sw && kind_ff == porc_pkg::PORC_IDLE) begin
      nxt_kind = porc_pkg::PORC_SW;
      nxt_cnt  = PULSE_LOAD;
    end else if (cnt_ff != 8'h00) begin
      nxt_cnt = cnt_ff - 8'h01;
    end else begin
      nxt_kind = porc_pkg::PORC_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kind_ff <= porc_pkg::PORC_POR;
      cnt_ff  <= PULSE_LOAD;
    end else begin
      kind_ff <= nxt_kind;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Separate lines, each a flip-flop
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_rst_out  <= 1'b1;
      hw_rst_out   <= 1'b0;
      sw_rst_out   <= 1'b0;
      boot_req_out <= 1'b0;
    end else begin
      por_rst_out  <= nxt_kind == porc_pkg::PORC_POR;
      hw_rst_out   <= nxt_kind == porc_pkg::PORC_HW;
      sw_rst_out   <= nxt_kind == porc_pkg::PORC_SW;
      boot_req_out <= (kind_ff == porc_pkg::PORC_POR || kind_ff == porc_pkg::PORC_HW)
                      && nxt_kind == porc_pkg::PORC_IDLE;
    end
  end

  // Nested scopes of the three lines
  assign dom_por = por_rst_out;
  assign dom_hw  = por_rst_out || hw_rst_out;
  assign dom_sw  = dom_hw || sw_rst_out;

  // Cause latch; a reset of a new kind overwrites the old cause, a retrigger of the same kind keeps it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_ff <= porc_pkg::STAT_RST;
    end else if (nxt_kind != kind_ff && nxt_kind != porc_pkg::PORC_IDLE) begin
      stat_ff <= '0;
      unique case (nxt_kind)
        porc_pkg::PORC_POR: stat_ff[porc_pkg::STAT_POR_BIT] <= 1'b1;
        porc_pkg::PORC_HW: begin
          stat_ff[porc_pkg::STAT_HW_BIT]   <= 1'b1;
          stat_ff[porc_pkg::STAT_WAKE_BIT] <= wake_hit && !short_press;
        end
        porc_pkg::PORC_SW: stat_ff[porc_pkg::STAT_SW_BIT] <= 1'b1;
        porc_pkg::PORC_IDLE: stat_ff <= stat_ff;
      endcase
    end
  end

  // Power-on domain: pin polarity and delay factor; pin select clears on every reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sel_ff  <= SEL_W'(porc_pkg::PIN_SEL_RST);
      pin_pol_ff  <= porc_pkg::PIN_POL_RST;
      por_time_ff <= porc_pkg::POR_TIME_RST;
    end else begin
      if (dom_sw) begin
        pin_sel_ff <= SEL_W'(porc_pkg::PIN_SEL_RST);
      end else if (wr_in && addr_in == porc_pkg::OFS_PIN_SEL) begin
        pin_sel_ff <= wdata_in[SEL_W-1:0];
      end
      if (dom_por) begin
        pin_pol_ff  <= porc_pkg::PIN_POL_RST;
        por_time_ff <= porc_pkg::POR_TIME_RST;
      end else begin
        if (wr_in && addr_in == porc_pkg::OFS_PIN_SEL) begin
          pin_pol_ff <= wdata_in[porc_pkg::PIN_POL_BIT];
        end
        if (wr_in && addr_in == porc_pkg::OFS_POR_TIMER) begin
          por_time_ff <= wdata_in[6:0];
        end
      end
    end
  end

  // Hardware domain: system, power and pull control
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rc_en_ff          <= porc_pkg::RC_EN_RST;
      row_ff            <= 1'b0;
      pull_override_out <= 1'b0;
    end else if (dom_hw) begin
      rc_en_ff          <= porc_pkg::RC_EN_RST;
      row_ff            <= 1'b0;
      pull_override_out <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == porc_pkg::OFS_SYS_CTRL) begin
        rc_en_ff <= wdata_in[porc_pkg::SYSC_RC_EN_BIT];
      end
      if (addr_in == porc_pkg::OFS_PMU_CTRL) begin
        row_ff <= wdata_in[porc_pkg::PMU_ROW_BIT];
      end
      if (addr_in == porc_pkg::OFS_PULL_OVR) begin
        pull_override_out <= wdata_in[0];
      end
    end
  end

  // Software domain: general storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scratch_ff <= 32'h00000000;
    end else if (dom_sw) begin
      scratch_ff <= 32'h00000000;
    end else if (wr_in && addr_in == porc_pkg::OFS_SCRATCH) begin
      scratch_ff <= wdata_in;
    end
  end

  // Any asserted source overrides a software disable of the oscillator
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_rc_en_out <= porc_pkg::RC_EN_RST;
    end else begin
      slow_rc_en_out <= rc_en_ff || pad_s || gpio_act;
    end
  end

  // Read data in the cycle after the strobe only
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      unique case (addr_in)
        porc_pkg::OFS_SYS_CTRL:  rdata_out <= {30'h0, rc_en_ff, 1'b0};
        porc_pkg::OFS_PMU_CTRL:  rdata_out <= {31'h0, row_ff};
        porc_pkg::OFS_PIN_SEL:   rdata_out <= {27'h0, pin_pol_ff, 4'(pin_sel_ff)};
        porc_pkg::OFS_POR_TIMER: rdata_out <= {25'h0, por_time_ff};
        porc_pkg::OFS_RST_STAT:  rdata_out <= {28'h0, stat_ff};
        porc_pkg::OFS_PULL_OVR:  rdata_out <= {31'h0, pull_override_out};
        porc_pkg::OFS_SCRATCH:   rdata_out <= scratch_ff;
        default:                 rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_short_press;
    pad_s && !pad_spent_ff ##1 !pad_s;
  endsequence
  sequence s_pad_spent;
    pad_s && timer_fire ##1 pad_s;
  endsequence
  property p_short_hw;
    s_short_press |=> hw_rst_out || por_rst_out;
  endproperty
  a_short_hw: assert property (p_short_hw)
    else $error("short pad press gave no hardware reset");
  property p_expire_por;
    timer_fire |=> por_rst_out [*2];
  endproperty
  a_expire_por: assert property (p_expire_por)
    else $error("timer expiry gave no power-on reset");
  property p_pad_once;
    s_pad_spent |-> pad_spent_ff && !src_run || gpio_act;
  endproperty
  a_pad_once: assert property (p_pad_once)
    else $error("pad run restarted while still held");
  property p_osc_forced;
    (pad_s || gpio_act) |=> slow_rc_en_out;
  endproperty
  a_osc_forced: assert property (p_osc_forced)
    else $error("slow oscillator not forced on");
  property p_sel_zero;
    pin_sel_ff == '0 |-> !gpio_act;
  endproperty
  a_sel_zero: assert property (p_sel_zero)
    else $error("gpio source active with select zero");
  property p_key_sw;
    key_hit && kind_ff == porc_pkg::PORC_IDLE && !req_por && !req_hw
      |=> sw_rst_out ##1 stat_ff[porc_pkg::STAT_SW_BIT];
  endproperty
  a_key_sw: assert property (p_key_sw)
    else $error("keyed request gave no software reset");
  property p_supply;
    !sup_ok |=> por_rst_out && !boot_req_out;
  endproperty
  a_supply: assert property (p_supply)
    else $error("power-on not held with bad supply");
  property p_sel_cleared;
    sw_rst_out |=> pin_sel_ff == '0;
  endproperty
  a_sel_cleared: assert property (p_sel_cleared)
    else $error("pin select survived a reset");
  property p_wake_hw;
    wake_hit && kind_ff != porc_pkg::PORC_POR && !req_por |=> hw_rst_out;
  endproperty
  a_wake_hw: assert property (p_wake_hw)
    else $error("wakeup gave no hardware reset");
  property p_sw_no_boot;
    $fell(sw_rst_out) && !hw_rst_out && !por_rst_out |-> !boot_req_out;
  endproperty
  a_sw_no_boot: assert property (p_sw_no_boot)
    else $error("software reset started a cold boot");
endmodule
